// ==== iodt_map.svh ====
/*
 holds the opcode patterns, field positions and clock counts of the decode
 and timing model; assumes inclusion by the decoder only.
*/
// Contract
// RULE_01: register copy forms take one clock
// RULE_02: immediate copy long and short forms, one clock
// RULE_03: accumulator displacement copies one clock, load miss
// RULE_04: extending copy three clocks, z picks sign
// RULE_05: stack store short, immediate one; long four
// RULE_06: stack load short one; memory form six
// RULE_07: swap three between registers, five with memory
// RULE_08: address load one, two with index
// RULE_09: three-bit operation field decodes eight ways
// RULE_10: bus timing given as r-b-w, fastest 2-1-2
// RULE_11: slower bus adds r-2 to miss
// RULE_12: misaligned access adds three clocks
// RULE_13: base from previous destination adds one
// RULE_14: index register adds one clock
// RULE_15: displacement with immediate adds one clock
// RULE_16: jump target miss adds r, 3b, r+3b
// RULE_17: access to filling line stalls until done
// RULE_18: write buffer wait adds w per entry
// RULE_19: each contending invalidate cycle adds one
// RULE_20: translation miss adds 13, 21 or 28
// RULE_21: unaligned multi-read miss adds r+3b fill
// RULE_22: size bit selects byte or full width
// RULE_23: form field 11 picks register operand
`ifndef IODT_MAP_SVH
`define IODT_MAP_SVH
`define IODT_ESCAPE 8'h0F
`define IODT_ACC_HI 3'h5
`define IODT_BASE_CLK 5'h01
`define IODT_EXT_CLK 5'h03
`define IODT_STK_LONG_CLK 5'h04
`define IODT_SWAP_MEM_CLK 5'h05
`define IODT_POP_MEM_CLK 5'h06
`define IODT_MISS_PEN 5'h02
`define IODT_MISALIGN_PEN 5'h03
`define IODT_FAST_R 4'h2
`define IODT_FAST_B 4'h1
`define IODT_FAST_W 4'h2
`define IODT_TLB_PEN0 6'h0D
`define IODT_TLB_PEN1 6'h15
`define IODT_TLB_PEN2 6'h1C
`define IODT_FORM_REG 2'h3
`define IODT_SIZE_POS 0
`define IODT_Z_POS 3
`endif

// ==== iodt_pkg.sv ====
/*
 holds the types of the decode and timing model; assumes the map header.
*/
package iodt_pkg;
   typedef enum logic [3:0] {
      IODT_OP_NONE = 4'h0,
      IODT_OP_COPY = 4'h1,
      IODT_OP_COPY_IMM = 4'h2,
      IODT_OP_COPY_ACC = 4'h3,
      IODT_OP_EXTEND = 4'h4,
      IODT_OP_STORE = 4'h5,
      IODT_OP_LOAD = 4'h6,
      IODT_OP_SWAP = 4'h7,
      IODT_OP_EAL = 4'h8
   } iodt_class_e;
   typedef enum logic [2:0] {
      IODT_ALU_SUM = 3'h0,
      IODT_ALU_OR = 3'h1,
      IODT_ALU_SUMC = 3'h2,
      IODT_ALU_DIFB = 3'h3,
      IODT_ALU_AND = 3'h4,
      IODT_ALU_DIF = 3'h5,
      IODT_ALU_XOR = 3'h6,
      IODT_ALU_RSV = 3'h7
   } iodt_alu_e;
   typedef enum logic [1:0] {
      IODT_ST_IDLE = 2'h0,
      IODT_ST_BUSY = 2'h1,
      IODT_ST_STALL = 2'h3
   } iodt_state_e;
endpackage

// ==== iodt_decode.sv ====
/*
 decodes one instruction and counts out its clocks; assumes the issuer holds
 the instruction steady while ISSUE is high and waits for DONE.
*/
`timescale 1ns/1ns
`include "iodt_map.svh"
module iodt_decode #(
   parameter logic [3:0] BUS_R = `IODT_FAST_R,
   parameter logic [3:0] BUS_B = `IODT_FAST_B,
   parameter logic [3:0] BUS_W = `IODT_FAST_W
) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic ISSUE,
   input wire logic [7:0] OPCODE,
   input wire logic [7:0] OPCODE2,
   input wire logic [7:0] OPERAND_LOCATOR,
   input wire logic HAS_INDEX,
   input wire logic HAS_DISP,
   input wire logic HAS_IMM,
   input wire logic [2:0] BASE_REG,
   input wire logic DATA_MISS,
   input wire logic MISALIGNED,
   input wire logic JUMP_MISS,
   input wire logic [1:0] JUMP_SPAN,
   input wire logic MULTI_UNALIGNED,
   input wire logic [1:0] WBUF_ENTRIES,
   input wire logic TLB_MISS,
   input wire logic [1:0] TLB_AD_WRITES,
   input wire logic FILL_BUSY,
   input wire logic INVALIDATE,
   output iodt_pkg::iodt_class_e OP_CLASS,
   output iodt_pkg::iodt_alu_e ALU_OP,
   output logic OPERAND_WIDE,
   output logic OPERAND_REG,
   output logic SIGN_EXTEND,
   output logic [2:0] DEST_REG,
   output logic [7:0] CLOCKS,
   output logic BUSY,
   output logic DONE
);
   import iodt_pkg::*;

   iodt_state_e state_ff, nxt_state;
   iodt_class_e class_ff;
   iodt_alu_e alu_ff;
   logic wide_ff, reg_ff, sext_ff, done_ff, busy_ff;
   logic [2:0] dest_ff;
   logic [7:0] count_ff, total_ff;
   iodt_class_e cls;
   logic [7:0] base_clk, extra;
   logic is_reg, is_load, is_mem;

   // cache-miss penalty widened for the bus speed
   function automatic logic [7:0] miss_pen();
      // RULE_10 RULE_11: r-2 on slower bus
      return 8'(`IODT_MISS_PEN) + 8'(BUS_R) - 8'(`IODT_FAST_R);
   endfunction

   // RULE_23: form field 11 register
   assign is_reg = (OPERAND_LOCATOR[7:6] == `IODT_FORM_REG);

   always_comb begin
      cls = IODT_OP_NONE;
      base_clk = 8'(`IODT_BASE_CLK);
      is_load = 1'b0;
      is_mem = !is_reg;
      if (OPCODE[7:2] == 6'h22) begin
         // RULE_01: register copy forms
         cls = IODT_OP_COPY;
         is_load = OPCODE[1];
      end else if (OPCODE[7:1] == 7'h63 && OPERAND_LOCATOR[5:3] == 3'h0) begin
         // RULE_02: long immediate copy
         cls = IODT_OP_COPY_IMM;
      end else if (OPCODE[7:4] == 4'hB) begin
         // RULE_02: short immediate copy
         cls = IODT_OP_COPY_IMM;
         is_mem = 1'b0;
      end else if (OPCODE[7:2] == 6'h28) begin
         // RULE_03: accumulator displacement copy
         cls = IODT_OP_COPY_ACC;
         is_load = !OPCODE[1];
         is_mem = 1'b1;
      end else if (OPCODE == `IODT_ESCAPE && OPCODE2[7:4] == 4'hB && OPCODE2[2:1] == 2'h3) begin
         // RULE_04: extending copy three clocks
         cls = IODT_OP_EXTEND;
         base_clk = 8'(`IODT_EXT_CLK);
         is_load = 1'b1;
      end else if (OPCODE[7:3] == 5'h0A || OPCODE[7:3] == 5'h0B) begin
         // RULE_05 RULE_06: short stack forms
         cls = OPCODE[3] ? IODT_OP_LOAD : IODT_OP_STORE;
         is_mem = 1'b0;
      end else if (OPCODE[7:2] == 6'h1A && !OPCODE[0]) begin
         // RULE_05: immediate stack store
         cls = IODT_OP_STORE;
         is_mem = 1'b0;
      end else if (OPCODE == 8'hFF && OPERAND_LOCATOR[5:3] == 3'h6) begin
         // RULE_05: long stack store four
         cls = IODT_OP_STORE;
         base_clk = 8'(`IODT_STK_LONG_CLK);
      end else if (OPCODE == 8'h8F && OPERAND_LOCATOR[5:3] == 3'h0) begin
         // RULE_06: memory stack load six
         cls = IODT_OP_LOAD;
         is_load = 1'b1;
         base_clk = is_reg ? 8'(`IODT_STK_LONG_CLK) : 8'(`IODT_POP_MEM_CLK);
      end else if (OPCODE[7:1] == 7'h43 || OPCODE[7:3] == 5'h12) begin
         // RULE_07: swap three or five
         cls = IODT_OP_SWAP;
         if (OPCODE[7:3] == 5'h12)
            is_mem = 1'b0;
         base_clk = (OPCODE[7:1] == 7'h43 && !is_reg) ? 8'(`IODT_SWAP_MEM_CLK) : 8'(`IODT_EXT_CLK);
      end else if (OPCODE == 8'h8D) begin
         // RULE_08: address load plus index
         cls = IODT_OP_EAL;
         is_mem = 1'b0;
      end
   end

   always_comb begin
      extra = 8'h00;
      if (DATA_MISS && is_load && is_mem)
         extra = extra + miss_pen();
      // RULE_12: misaligned access three
      if (MISALIGNED && is_mem)
         extra = extra + 8'(`IODT_MISALIGN_PEN);
      // RULE_13: base dependency one
      if (class_ff != IODT_OP_NONE && !is_reg && BASE_REG == dest_ff)
         extra = extra + 8'h01;
      // RULE_14 RULE_08: index adds one
      if (HAS_INDEX && !is_reg)
         extra = extra + 8'h01;
      // RULE_15: displacement with immediate
      if (HAS_DISP && HAS_IMM)
         extra = extra + 8'h01;
      // RULE_16: jump target miss
      if (JUMP_MISS) begin
         extra = extra + 8'(BUS_R);
         if (JUMP_SPAN != 2'h0)
            extra = extra + 8'(3 * BUS_B);
         if (JUMP_SPAN == 2'h2)
            extra = extra + 8'(BUS_R) + 8'(3 * BUS_B);
      end
      // RULE_18: write buffer drain
      extra = extra + 8'(WBUF_ENTRIES) * 8'(BUS_W);
      // RULE_20: translation miss
      if (TLB_MISS)
         extra = extra + (TLB_AD_WRITES == 2'h0 ? 8'(`IODT_TLB_PEN0) :
                          TLB_AD_WRITES == 2'h1 ? 8'(`IODT_TLB_PEN1) : 8'(`IODT_TLB_PEN2));
      // RULE_21: unaligned multi-read fill
      if (MULTI_UNALIGNED && DATA_MISS)
         extra = extra + 8'(BUS_R) + 8'(3 * BUS_B);
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         IODT_ST_IDLE: begin
            if (ISSUE)
               nxt_state = IODT_ST_BUSY;
         end
         IODT_ST_BUSY, IODT_ST_STALL: begin
            // RULE_17 RULE_19: fill and invalidate stall
            if (FILL_BUSY || INVALIDATE)
               nxt_state = IODT_ST_STALL;
            else if (count_ff <= 8'h01)
               nxt_state = IODT_ST_IDLE;
            else
               nxt_state = IODT_ST_BUSY;
         end
         default: nxt_state = IODT_ST_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N)
         state_ff <= IODT_ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   // clock counter and total
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         count_ff <= 8'h00;
         total_ff <= 8'h00;
      end else if (state_ff == IODT_ST_IDLE && ISSUE) begin
         count_ff <= base_clk + extra;
         total_ff <= base_clk + extra;
      end else if (state_ff != IODT_ST_IDLE && (FILL_BUSY || INVALIDATE)) begin
         // RULE_17 RULE_19: stalled clock counted
         total_ff <= total_ff + 8'h01;
      end else if (state_ff != IODT_ST_IDLE) begin
         count_ff <= count_ff - 8'h01;
      end
   end

   // decoded fields
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         class_ff <= IODT_OP_NONE;
         alu_ff <= IODT_ALU_SUM;
         wide_ff <= 1'b0;
         reg_ff <= 1'b0;
         sext_ff <= 1'b0;
         dest_ff <= 3'h0;
      end else if (state_ff == IODT_ST_IDLE && ISSUE) begin
         class_ff <= cls;
         // RULE_09: operation field decode
         alu_ff <= iodt_alu_e'(OPERAND_LOCATOR[5:3]);
         // RULE_22: size bit width
         wide_ff <= (OPCODE[7:4] == 4'hB) ? OPCODE[3] :
                    (cls == IODT_OP_EXTEND) ? OPCODE2[`IODT_SIZE_POS] : OPCODE[`IODT_SIZE_POS];
         reg_ff <= !is_mem;
         // RULE_04: z selects sign
         sext_ff <= (cls == IODT_OP_EXTEND) && OPCODE2[`IODT_Z_POS];
         dest_ff <= (OPCODE[7:4] == 4'hB || OPCODE[7:4] == 4'h5 || OPCODE[7:3] == 5'h12) ?
                    OPCODE[2:0] : OPERAND_LOCATOR[5:3];
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         done_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         done_ff <= (state_ff != IODT_ST_IDLE) && (nxt_state == IODT_ST_IDLE);
         busy_ff <= (nxt_state != IODT_ST_IDLE);
      end
   end

   assign OP_CLASS = class_ff;
   assign ALU_OP = alu_ff;
   assign OPERAND_WIDE = wide_ff;
   assign OPERAND_REG = reg_ff;
   assign SIGN_EXTEND = sext_ff;
   assign DEST_REG = dest_ff;
   assign CLOCKS = total_ff;
   assign BUSY = busy_ff;
   assign DONE = done_ff;
endmodule

// ==== iodt_cache_model.sv ====
/*
 cache fill and invalidate stalls seen by the decoder.
 assumes the bench pulses go with the issue and sets both lengths.
*/
`timescale 1ns/1ns
module iodt_cache_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic [3:0] fill_len,
   input wire logic [3:0] inv_len,
   output logic fill_busy,
   output logic invalidate
);
   logic [3:0] fill_ff;
   logic [3:0] inv_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) fill_ff <= 4'h0;
      else if (go) fill_ff <= fill_len;
      else if (fill_ff != 4'h0) fill_ff <= fill_ff - 4'h1;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) inv_ff <= 4'h0;
      else if (go) inv_ff <= inv_len;
      else if (inv_ff != 4'h0) inv_ff <= inv_ff - 4'h1;
   end
   assign fill_busy = fill_ff != 4'h0;
   assign invalidate = inv_ff != 4'h0;
endmodule

// ==== iodt_decode_sva.sv ====
/*
 port checks of the decoder.
 assumes binding onto iodt_decode.
*/
`timescale 1ns/1ns
module iodt_decode_sva (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic ISSUE,
   input wire logic [7:0] OPCODE,
   input wire logic [7:0] OPCODE2,
   input wire logic [7:0] OPERAND_LOCATOR,
   input wire logic MISALIGNED,
   input wire logic JUMP_MISS,
   input wire logic [1:0] WBUF_ENTRIES,
   input wire logic TLB_MISS,
   input wire logic [1:0] TLB_AD_WRITES,
   input wire iodt_pkg::iodt_class_e OP_CLASS,
   input wire logic OPERAND_WIDE,
   input wire logic OPERAND_REG,
   input wire logic SIGN_EXTEND,
   input wire logic [7:0] CLOCKS,
   input wire logic BUSY,
   input wire logic DONE
);
   import iodt_pkg::*;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   wire take = ISSUE && !BUSY;
   wire clean = !JUMP_MISS && WBUF_ENTRIES == 2'h0;
   wire copy = take && OPCODE[7:2] == 6'h22;
   wire rcopy = copy && OPERAND_LOCATOR[7:6] == 2'h3 && clean && !TLB_MISS && !MISALIGNED;
   wire ext = take && OPCODE == 8'h0F && OPCODE2[7:4] == 4'hB && OPCODE2[2:1] == 2'h3;
   wire mst = take && OPCODE == 8'h89 && OPERAND_LOCATOR[7:6] == 2'h0 && clean;
   done_pulse_a: assert property (DONE |=> !DONE) else $error("done held");
   hold_class_a: assert property (BUSY |=> $stable(OP_CLASS)) else $error("class moved");
   done_bound_a: assert property ($rose(BUSY) |-> ##[1:100] DONE) else $error("no done");
   copy_time_a: assert property (rcopy |=> CLOCKS == 8'h01 ##1 DONE) else $error("copy time");
   ext_time_a: assert property (ext && OPERAND_LOCATOR[7:6] == 2'h3 && clean && !TLB_MISS |=>
      CLOCKS == 8'h03 ##3 DONE) else $error("extend time");
   ext_kind_a: assert property (ext |=> SIGN_EXTEND == $past(OPCODE2[3])) else $error("extend kind");
   size_bit_a: assert property (copy |=> OPERAND_WIDE == $past(OPCODE[0])) else $error("size bit");
   form_reg_a: assert property (copy |=> OPERAND_REG == ($past(OPERAND_LOCATOR[7:6]) == 2'h3))
      else $error("form field");
   tlb_cost_a: assert property (mst && !MISALIGNED && TLB_MISS && TLB_AD_WRITES == 2'h2 |=>
      CLOCKS == 8'h1D) else $error("tlb cost");
   mis_cost_a: assert property (mst && MISALIGNED && !TLB_MISS |=> CLOCKS == 8'h04)
      else $error("misalign cost");
endmodule

// ==== tb.sv ====
/*
 self-checking bench of iodt_decode with a slow bus.
 assumes the cache model and the checker files.
*/
`timescale 1ns/1ns
module tb;
   import iodt_pkg::*;
   localparam logic [7:0] R = 8'h04;
   localparam logic [7:0] B = 8'h01;
   localparam logic [7:0] W = 8'h02;
   logic REF_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic ISSUE, HAS_INDEX, HAS_DISP, HAS_IMM, DATA_MISS, MISALIGNED, JUMP_MISS, MULTI_UNALIGNED, TLB_MISS, go;
   logic [7:0] OPCODE, OPCODE2, OPERAND_LOCATOR, CLOCKS;
   logic [2:0] BASE_REG, DEST_REG;
   logic [1:0] JUMP_SPAN, WBUF_ENTRIES, TLB_AD_WRITES;
   logic [3:0] fill_len, inv_len;
   logic FILL_BUSY, INVALIDATE, OPERAND_WIDE, OPERAND_REG, SIGN_EXTEND, BUSY, DONE;
   iodt_class_e OP_CLASS;
   iodt_alu_e ALU_OP;
   int bad_count = 0;
   int num_checks = 0;
   always #50 REF_CLK = ~REF_CLK;
   iodt_decode #(.BUS_R(4'h4), .BUS_B(4'h1), .BUS_W(4'h2)) i_dut (.REF_CLK(REF_CLK), .RST_N(RST_N),
      .ISSUE(ISSUE), .OPCODE(OPCODE), .OPCODE2(OPCODE2), .OPERAND_LOCATOR(OPERAND_LOCATOR), .HAS_INDEX(HAS_INDEX),
      .HAS_DISP(HAS_DISP), .HAS_IMM(HAS_IMM), .BASE_REG(BASE_REG), .DATA_MISS(DATA_MISS), .MISALIGNED(MISALIGNED),
      .JUMP_MISS(JUMP_MISS), .JUMP_SPAN(JUMP_SPAN), .MULTI_UNALIGNED(MULTI_UNALIGNED), .WBUF_ENTRIES(WBUF_ENTRIES),
      .TLB_MISS(TLB_MISS), .TLB_AD_WRITES(TLB_AD_WRITES), .FILL_BUSY(FILL_BUSY), .INVALIDATE(INVALIDATE),
      .OP_CLASS(OP_CLASS), .ALU_OP(ALU_OP), .OPERAND_WIDE(OPERAND_WIDE), .OPERAND_REG(OPERAND_REG),
      .SIGN_EXTEND(SIGN_EXTEND), .DEST_REG(DEST_REG), .CLOCKS(CLOCKS), .BUSY(BUSY), .DONE(DONE));
   iodt_cache_model i_mem (.clk(REF_CLK), .rst_n(RST_N), .go(go), .fill_len(fill_len), .inv_len(inv_len),
      .fill_busy(FILL_BUSY), .invalidate(INVALIDATE));
   task automatic chk(input string w, input logic [7:0] e, input logic [7:0] s);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("FAIL %s exp %0h got %0h", w, e, s);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic run(input logic [7:0] op, op2, loc, e, input iodt_class_e c);
      int n;
      n = 0;
      OPCODE = op;
      OPCODE2 = op2;
      OPERAND_LOCATOR = loc;
      ISSUE = 1'b1;
      @(posedge REF_CLK);
      #1;
      ISSUE = 1'b0;
      chk("busy", 8'h01, {7'h0, BUSY});
      {HAS_INDEX, HAS_DISP, HAS_IMM, DATA_MISS, MISALIGNED, JUMP_MISS, MULTI_UNALIGNED, TLB_MISS, go} = 9'h000;
      {JUMP_SPAN, WBUF_ENTRIES, TLB_AD_WRITES} = 6'h00;
      while (DONE !== 1'b1) begin
         @(posedge REF_CLK);
         #1;
         n++;
         if (n > 99) begin
            chk("timeout", 8'h00, 8'h01);
            complete_run();
         end
      end
      chk("clocks", e, CLOCKS);
      chk("latency", e, 8'(n));
      chk("busy", 8'h00, {7'h0, BUSY});
      chk("class", {4'h0, c}, {4'h0, OP_CLASS});
   endtask
   task automatic t_copy();
      run(8'h89, 8'h00, 8'hC8, 8'h01, IODT_OP_COPY);
      chk("wide", 8'h01, {7'h0, OPERAND_WIDE});
      run(8'h8A, 8'h00, 8'hC8, 8'h01, IODT_OP_COPY);
      chk("wide", 8'h00, {7'h0, OPERAND_WIDE});
      DATA_MISS = 1'b1;
      run(8'h8B, 8'h00, 8'h00, 8'h01 + R, IODT_OP_COPY);
      chk("reg", 8'h00, {7'h0, OPERAND_REG});
      run(8'hC7, 8'h00, 8'hC0, 8'h01, IODT_OP_COPY_IMM);
      run(8'hB9, 8'h00, 8'h00, 8'h01, IODT_OP_COPY_IMM);
      DATA_MISS = 1'b1;
      run(8'hA1, 8'h00, 8'h00, 8'h01 + R, IODT_OP_COPY_ACC);
      run(8'hA3, 8'h00, 8'h00, 8'h01, IODT_OP_COPY_ACC);
   endtask
   task automatic t_ext();
      run(8'h0F, 8'hB6, 8'hC8, 8'h03, IODT_OP_EXTEND);
      chk("sign", 8'h00, {7'h0, SIGN_EXTEND});
      run(8'h0F, 8'hBF, 8'hC8, 8'h03, IODT_OP_EXTEND);
      chk("sign", 8'h01, {7'h0, SIGN_EXTEND});
      DATA_MISS = 1'b1;
      run(8'h0F, 8'hB7, 8'h00, 8'h03 + R, IODT_OP_EXTEND);
   endtask
   task automatic t_stack();
      run(8'h50, 8'h00, 8'h00, 8'h01, IODT_OP_STORE);
      run(8'h6A, 8'h00, 8'h00, 8'h01, IODT_OP_STORE);
      run(8'hFF, 8'h00, 8'hF0, 8'h04, IODT_OP_STORE);
      run(8'h58, 8'h00, 8'h00, 8'h01, IODT_OP_LOAD);
      DATA_MISS = 1'b1;
      run(8'h8F, 8'h00, 8'h00, 8'h06 + R, IODT_OP_LOAD);
      run(8'h87, 8'h00, 8'hC8, 8'h03, IODT_OP_SWAP);
      run(8'h91, 8'h00, 8'h00, 8'h03, IODT_OP_SWAP);
      run(8'h87, 8'h00, 8'h00, 8'h05, IODT_OP_SWAP);
      run(8'h8D, 8'h00, 8'h00, 8'h01, IODT_OP_EAL);
      HAS_INDEX = 1'b1;
      run(8'h8D, 8'h00, 8'h00, 8'h02, IODT_OP_EAL);
   endtask
   task automatic t_alu();
      for (int i = 0; i < 7; i++) begin
         run(8'h89, 8'h00, {2'h3, 3'(i), 3'h0}, 8'h01, IODT_OP_COPY);
         chk("alu", 8'(i), {5'h0, ALU_OP});
      end
   endtask
   task automatic t_pen();
      MISALIGNED = 1'b1;
      run(8'h89, 8'h00, 8'h00, 8'h04, IODT_OP_COPY);
      HAS_DISP = 1'b1;
      HAS_IMM = 1'b1;
      run(8'hC7, 8'h00, 8'h40, 8'h02, IODT_OP_COPY_IMM);
      for (int k = 0; k < 3; k++) begin
         TLB_MISS = 1'b1;
         TLB_AD_WRITES = 2'(k);
         run(8'h89, 8'h00, 8'h00, k == 0 ? 8'd14 : k == 1 ? 8'd22 : 8'd29, IODT_OP_COPY);
         JUMP_MISS = 1'b1;
         JUMP_SPAN = 2'(k);
         run(8'h89, 8'h00, 8'h00, 8'h01 + R + (k > 0 ? 8'h03 * B : 8'h00) + (k > 1 ? R + 8'h03 * B : 8'h00),
            IODT_OP_COPY);
      end
      WBUF_ENTRIES = 2'h2;
      run(8'h89, 8'h00, 8'h00, 8'h01 + 8'h02 * W, IODT_OP_COPY);
      DATA_MISS = 1'b1;
      MULTI_UNALIGNED = 1'b1;
      run(8'h8F, 8'h00, 8'h00, 8'h06 + R + R + 8'h03 * B, IODT_OP_LOAD);
      run(8'hBB, 8'h00, 8'h00, 8'h01, IODT_OP_COPY_IMM);
      chk("dest", 8'h03, {5'h0, DEST_REG});
      BASE_REG = 3'h3;
      run(8'h89, 8'h00, 8'h00, 8'h02, IODT_OP_COPY);
      BASE_REG = 3'h7;
   endtask
   task automatic t_stall();
      go = 1'b1;
      fill_len = 4'h3;
      run(8'h8F, 8'h00, 8'h00, 8'h09, IODT_OP_LOAD);
      go = 1'b1;
      fill_len = 4'h0;
      inv_len = 4'h2;
      run(8'h8F, 8'h00, 8'h00, 8'h08, IODT_OP_LOAD);
   endtask
   initial begin
      {ISSUE, HAS_INDEX, HAS_DISP, HAS_IMM, DATA_MISS, MISALIGNED, JUMP_MISS, MULTI_UNALIGNED, TLB_MISS, go} = 10'h000;
      {OPCODE, OPCODE2, OPERAND_LOCATOR} = 24'h000000;
      {JUMP_SPAN, WBUF_ENTRIES, TLB_AD_WRITES, fill_len, inv_len} = 14'h0000;
      BASE_REG = 3'h7;
      repeat (20) @(posedge REF_CLK);
      #1;
      RST_N = 1'b1;
      t_copy();
      t_ext();
      t_stack();
      t_alu();
      t_pen();
      t_stall();
      complete_run();
   end
endmodule
bind iodt_decode iodt_decode_sva i_sva (.REF_CLK(REF_CLK), .RST_N(RST_N), .ISSUE(ISSUE), .OPCODE(OPCODE),
   .OPCODE2(OPCODE2), .OPERAND_LOCATOR(OPERAND_LOCATOR), .MISALIGNED(MISALIGNED), .JUMP_MISS(JUMP_MISS),
   .WBUF_ENTRIES(WBUF_ENTRIES), .TLB_MISS(TLB_MISS), .TLB_AD_WRITES(TLB_AD_WRITES), .OP_CLASS(OP_CLASS),
   .OPERAND_WIDE(OPERAND_WIDE), .OPERAND_REG(OPERAND_REG), .SIGN_EXTEND(SIGN_EXTEND), .CLOCKS(CLOCKS),
   .BUSY(BUSY), .DONE(DONE));
